// >>> hw/dma_ctrl_pkg.sv
package dma_ctrl_pkg;
  localparam int PTR_W = 20;
  localparam int CNT_W = 16;

  // Register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_SRC0 = 8'h20;
  localparam logic [7:0] ADDR_DST0 = 8'h23;
  localparam logic [7:0] ADDR_CNT0 = 8'h26;
  localparam logic [7:0] ADDR_MEM1 = 8'h28;
  localparam logic [7:0] ADDR_IO1 = 8'h2b;
  localparam logic [7:0] ADDR_CNT1 = 8'h2e;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_MODE = 8'h31;
  localparam logic [7:0] ADDR_WAITCTL = 8'h32;

  // dma_status_enable fields
  localparam int ST_CH1_ENABLE = 7;
  localparam int ST_CH0_ENABLE = 6;
  localparam int ST_CH1_WMASK = 5;
  localparam int ST_CH0_WMASK = 4;
  localparam int ST_CH1_IRQ_EN = 3;
  localparam int ST_CH0_IRQ_EN = 2;
  localparam int ST_MASTER = 0;

  // dma_ch0_mode fields
  localparam int MODE_DEST_LSB = 4;
  localparam int MODE_SRC_LSB = 2;
  localparam int MODE_TIMING = 1;
  localparam logic [7:0] MODE_WRITABLE = 8'h3e;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // dma_wait_control fields
  localparam int WC_SENSE_LSB = 2;
  localparam int WC_CH1_DIR = 1;
  localparam int WC_CH1_DEC = 0;
  localparam logic [7:0] WAITCTL_RESET = 8'hf0;

  // Pointer kind codes
  localparam logic [1:0] KIND_MEM_INC = 2'h0;
  localparam logic [1:0] KIND_MEM_DEC = 2'h1;
  localparam logic [1:0] KIND_MEM_FIX = 2'h2;
  localparam logic [1:0] KIND_IO_FIX = 2'h3;

  typedef enum logic [1:0] {
    PACE_IDLE = 2'b00,
    PACE_MOVE = 2'b01,
    PACE_GIVE = 2'b11
  } pace_t;
endpackage : dma_ctrl_pkg

// >>> hw/request_sense.sv
`timescale 1ns/10ps
module request_sense (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_pin_in,
  input wire logic edge_mode_in,
  input wire logic taken_in,
  output logic pending_out
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic edge_q;
  logic edge_d;
  wire rise = sync2_q & ~prev_q;

  // A new edge wins over the clear from a taken transfer
  assign edge_d = edge_mode_in & (rise | (edge_q & ~taken_in)); // R14
  assign pending_out = edge_mode_in ? edge_q : sync2_q; // R18

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      sync1_q <= req_pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      edge_q <= edge_d;
    end
  end
endmodule : request_sense

// >>> hw/dma_ctrl.sv
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
// Behaviour
// (R1) Transfer only with channel and master enable
// (R2) Non-maskable interrupt clears master enable
// (R3) Writing channel enable one sets master enable
// (R4) Master enable read-only, indirect set only
// (R5) Destination field steps destination pointer
// (R6) Source field steps source pointer alike
// (R7) Fixed/IO with fixed/IO pair is reserved
// (R8) Fixed memory modes serve memory-mapped IO
// (R9) Memory moves ignore channel 0 request
// (R10) Timing bit: one burst, zero cycle steal
// (R11) Burst holds bus until count zero
// (R12) Cycle steal gives bus one cycle back
// (R13) IO transfers paced by request only
// (R14) Both requests sense by level or edge
// (R15) Channel 1 moves memory to/from IO only
// (R16) Software clears write mask to change enable
// (R17) Count zero clears enable, may interrupt
// (R18) Sense bit zero level, one edge
// (R19) Pointers and counts hold while suspended
module dma_ctrl (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic nmi_in,
  input wire logic ch0_request_in,
  input wire logic ch1_request_in,
  output logic irq_out,
  output logic bus_hold_out,
  output logic xfer_valid_out,
  output logic xfer_channel_out,
  output logic [19:0] src_addr_out,
  output logic [19:0] dst_addr_out,
  output logic src_is_io_out,
  output logic dst_is_io_out,
  output logic [7:0] wait_control_out
);
  localparam int PW = dma_ctrl_pkg::PTR_W;
  localparam int CW = dma_ctrl_pkg::CNT_W;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input logic [1:0] n);
    hit = (a >= base) && (a < (base + {6'h00, n}));
  endfunction : hit

  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [7:0] a,
                                           input logic [7:0] base, input logic [7:0] b);
    logic [7:0] off;
    off = a - base;
    put_byte = v;
    put_byte[off[1:0]*8 +: 8] = b;
  endfunction : put_byte

  function automatic logic [19:0] step(input logic [19:0] p, input logic [1:0] kind);
    case (kind)
      dma_ctrl_pkg::KIND_MEM_INC: step = p + 20'h0_0001;
      dma_ctrl_pkg::KIND_MEM_DEC: step = p - 20'h0_0001;
      default: step = p;
    endcase
  endfunction : step

  logic [PW-1:0] src0_q, dst0_q, mem1_q, io1_q;
  logic [CW-1:0] cnt0_q, cnt1_q;
  logic [PW-1:0] src0_d, dst0_d, mem1_d, io1_d;
  logic [CW-1:0] cnt0_d, cnt1_d;
  logic de0_q, de1_q, ch0_irq_enable_q, die1_q, dme_q;
  logic de0_d, de1_d, dme_d;
  logic [7:0] mode_q, waitctl_q, rdata_q;
  dma_ctrl_pkg::pace_t pace_q, pace_d;
  logic req0, req1;

  // Register port decode
  wire wr_status = wr_in && addr_in == dma_ctrl_pkg::ADDR_STATUS;
  wire wr_mode = wr_in && addr_in == dma_ctrl_pkg::ADDR_MODE;
  wire wr_wait = wr_in && addr_in == dma_ctrl_pkg::ADDR_WAITCTL;
  wire wr_src0 = wr_in && hit(addr_in, dma_ctrl_pkg::ADDR_SRC0, 2'd3);
  wire wr_dst0 = wr_in && hit(addr_in, dma_ctrl_pkg::ADDR_DST0, 2'd3);
  wire wr_cnt0 = wr_in && hit(addr_in, dma_ctrl_pkg::ADDR_CNT0, 2'd2);
  wire wr_mem1 = wr_in && hit(addr_in, dma_ctrl_pkg::ADDR_MEM1, 2'd3);
  wire wr_io1 = wr_in && hit(addr_in, dma_ctrl_pkg::ADDR_IO1, 2'd2);
  wire wr_cnt1 = wr_in && hit(addr_in, dma_ctrl_pkg::ADDR_CNT1, 2'd2);
  // Channel enable bits only take a write with their write mask written low
  wire set0 = wr_status && !wdata_in[dma_ctrl_pkg::ST_CH0_WMASK]; // R16
  wire set1 = wr_status && !wdata_in[dma_ctrl_pkg::ST_CH1_WMASK]; // R16
  wire dme_set = (set0 && wdata_in[dma_ctrl_pkg::ST_CH0_ENABLE]) ||
                 (set1 && wdata_in[dma_ctrl_pkg::ST_CH1_ENABLE]);

  // Channel 0 mode decode
  wire [1:0] dkind = mode_q[dma_ctrl_pkg::MODE_DEST_LSB +: 2];
  wire [1:0] skind = mode_q[dma_ctrl_pkg::MODE_SRC_LSB +: 2];
  wire burst = mode_q[dma_ctrl_pkg::MODE_TIMING];
  wire d_io = dkind == dma_ctrl_pkg::KIND_IO_FIX;
  wire s_io = skind == dma_ctrl_pkg::KIND_IO_FIX;
  wire ch0_io = d_io || s_io;
  // Reserved pairs never start rather than guess a pointer rule
  wire ch0_reserved = dkind[1] && skind[1]; // R7
  wire ch0_ready = de0_q && dme_q && cnt0_q != '0 && !ch0_reserved; // R1
  // Memory moves self-pace; IO moves wait for their request
  wire ch0_go = ch0_ready && (ch0_io ? req0 : pace_q != dma_ctrl_pkg::PACE_GIVE); // R9 R13
  wire ch0_last = cnt0_q == 16'h0001;
  wire ch1_ready = de1_q && dme_q && cnt1_q != '0; // R1
  wire ch1_go = ch1_ready && req1 && !ch0_go;
  wire ch1_last = cnt1_q == 16'h0001;
  wire ch1_to_mem = waitctl_q[dma_ctrl_pkg::WC_CH1_DIR];
  wire [1:0] mkind = {1'b0, waitctl_q[dma_ctrl_pkg::WC_CH1_DEC]}; // R15

  // Pacing of memory-to-memory moves
  always_comb begin
    if (!ch0_ready || ch0_io) begin
      pace_d = dma_ctrl_pkg::PACE_IDLE;
    end else if (ch0_go && ch0_last) begin
      pace_d = dma_ctrl_pkg::PACE_IDLE;
    end else begin
      case (pace_q)
        dma_ctrl_pkg::PACE_IDLE: pace_d = burst ? dma_ctrl_pkg::PACE_MOVE :
                                               dma_ctrl_pkg::PACE_GIVE; // R10
        dma_ctrl_pkg::PACE_MOVE: pace_d = burst ? dma_ctrl_pkg::PACE_MOVE :
                                               dma_ctrl_pkg::PACE_GIVE; // R11 R12
        dma_ctrl_pkg::PACE_GIVE: pace_d = dma_ctrl_pkg::PACE_MOVE; // R12
        default: pace_d = dma_ctrl_pkg::PACE_IDLE;
      endcase
    end
  end

  // Pointer and count updates; nothing moves unless a transfer goes
  assign src0_d = wr_src0 ? PW'(put_byte({4'h0, src0_q}, addr_in, dma_ctrl_pkg::ADDR_SRC0,
                                         wdata_in)) :
                  ch0_go ? step(src0_q, skind) : src0_q; // R6 R8 R19
  assign dst0_d = wr_dst0 ? PW'(put_byte({4'h0, dst0_q}, addr_in, dma_ctrl_pkg::ADDR_DST0,
                                         wdata_in)) :
                  ch0_go ? step(dst0_q, dkind) : dst0_q; // R5 R8 R19
  assign cnt0_d = wr_cnt0 ? CW'(put_byte({8'h00, cnt0_q}, addr_in, dma_ctrl_pkg::ADDR_CNT0,
                                         wdata_in)) :
                  ch0_go ? cnt0_q - 16'h0001 : cnt0_q; // R19
  assign mem1_d = wr_mem1 ? PW'(put_byte({4'h0, mem1_q}, addr_in, dma_ctrl_pkg::ADDR_MEM1,
                                         wdata_in)) :
                  ch1_go ? step(mem1_q, mkind) : mem1_q; // R15
  assign io1_d = wr_io1 ? PW'(put_byte({4'h0, io1_q}, addr_in, dma_ctrl_pkg::ADDR_IO1,
                                       wdata_in)) : io1_q;
  assign cnt1_d = wr_cnt1 ? CW'(put_byte({8'h00, cnt1_q}, addr_in, dma_ctrl_pkg::ADDR_CNT1,
                                         wdata_in)) :
                  ch1_go ? cnt1_q - 16'h0001 : cnt1_q;

  // Software writes win over termination in the same cycle
  assign de0_d = set0 ? wdata_in[dma_ctrl_pkg::ST_CH0_ENABLE] :
                 (ch0_go && ch0_last) ? 1'b0 : de0_q; // R17
  assign de1_d = set1 ? wdata_in[dma_ctrl_pkg::ST_CH1_ENABLE] :
                 (ch1_go && ch1_last) ? 1'b0 : de1_q;
  // NMI wins so a handler never sees DMA running
  assign dme_d = nmi_in ? 1'b0 : dme_set ? 1'b1 : dme_q; // R2 R3 R4

  wire [7:0] status_rd = {de1_q, de0_q, 2'b11, die1_q, ch0_irq_enable_q, 1'b0, dme_q};
  wire [7:0] rd_mux =
    addr_in == dma_ctrl_pkg::ADDR_STATUS ? status_rd :
    addr_in == dma_ctrl_pkg::ADDR_MODE ? (mode_q & dma_ctrl_pkg::MODE_WRITABLE) :
    addr_in == dma_ctrl_pkg::ADDR_WAITCTL ? waitctl_q :
    addr_in == 8'h20 ? src0_q[7:0] : addr_in == 8'h21 ? src0_q[15:8] :
    addr_in == 8'h22 ? {4'h0, src0_q[19:16]} :
    addr_in == 8'h23 ? dst0_q[7:0] : addr_in == 8'h24 ? dst0_q[15:8] :
    addr_in == 8'h25 ? {4'h0, dst0_q[19:16]} :
    addr_in == 8'h26 ? cnt0_q[7:0] : addr_in == 8'h27 ? cnt0_q[15:8] :
    addr_in == 8'h28 ? mem1_q[7:0] : addr_in == 8'h29 ? mem1_q[15:8] :
    addr_in == 8'h2a ? {4'h0, mem1_q[19:16]} :
    addr_in == 8'h2b ? io1_q[7:0] : addr_in == 8'h2c ? io1_q[15:8] :
    addr_in == 8'h2e ? cnt1_q[7:0] : addr_in == 8'h2f ? cnt1_q[15:8] : 8'h00;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sense
      logic pend;
      request_sense u_sense (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .req_pin_in(g == 0 ? ch0_request_in : ch1_request_in),
        .edge_mode_in(waitctl_q[dma_ctrl_pkg::WC_SENSE_LSB + g]), // R14 R18
        .taken_in(g == 0 ? (ch0_go && ch0_io) : ch1_go),
        .pending_out(pend)
      );
    end
  endgenerate
  assign req0 = g_sense[0].pend;
  assign req1 = g_sense[1].pend;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src0_q <= '0;
      dst0_q <= '0;
      cnt0_q <= '0;
      mem1_q <= '0;
      io1_q <= '0;
      cnt1_q <= '0;
      pace_q <= dma_ctrl_pkg::PACE_IDLE;
    end else begin
      src0_q <= src0_d;
      dst0_q <= dst0_d;
      cnt0_q <= cnt0_d;
      mem1_q <= mem1_d;
      io1_q <= io1_d;
      cnt1_q <= cnt1_d;
      pace_q <= pace_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      de0_q <= 1'b0;
      de1_q <= 1'b0;
      ch0_irq_enable_q <= 1'b0;
      die1_q <= 1'b0;
      dme_q <= 1'b0;
      mode_q <= dma_ctrl_pkg::MODE_RESET;
      waitctl_q <= dma_ctrl_pkg::WAITCTL_RESET;
      rdata_q <= 8'h00;
    end else begin
      de0_q <= de0_d;
      de1_q <= de1_d;
      dme_q <= dme_d;
      if (wr_status) begin
        ch0_irq_enable_q <= wdata_in[dma_ctrl_pkg::ST_CH0_IRQ_EN];
        die1_q <= wdata_in[dma_ctrl_pkg::ST_CH1_IRQ_EN];
      end
      if (wr_mode) begin
        mode_q <= wdata_in & dma_ctrl_pkg::MODE_WRITABLE;
      end
      if (wr_wait) begin
        waitctl_q <= wdata_in;
      end
      rdata_q <= rd_in ? rd_mux : 8'h00;
    end
  end

  // Transfer presentation, one byte per cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xfer_valid_out <= 1'b0;
      xfer_channel_out <= 1'b0;
      src_addr_out <= '0;
      dst_addr_out <= '0;
      src_is_io_out <= 1'b0;
      dst_is_io_out <= 1'b0;
    end else begin
      xfer_valid_out <= ch0_go || ch1_go;
      xfer_channel_out <= ch1_go;
      src_addr_out <= ch0_go ? src0_q : ch1_to_mem ? io1_q : mem1_q;
      dst_addr_out <= ch0_go ? dst0_q : ch1_to_mem ? mem1_q : io1_q;
      src_is_io_out <= ch0_go ? s_io : ch1_to_mem;
      dst_is_io_out <= ch0_go ? d_io : !ch1_to_mem;
    end
  end

  assign bus_hold_out = xfer_valid_out;
  assign rdata_out = rdata_q;
  assign wait_control_out = waitctl_q;
  assign irq_out = (!de0_q && ch0_irq_enable_q) || (!de1_q && die1_q); // R17

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_give_back;
    !ch0_go ##1 ch0_go;
  endsequence

  a_run_needs_enables: assert property ( // R1
    xfer_valid_out && !xfer_channel_out |-> $past(de0_q) && $past(dme_q))
    else $error("channel 0 moved without both enables");
  a_nmi_clears_master: assert property (nmi_in |=> !dme_q) // R2
    else $error("master enable survived nmi");
  a_resume_sets_master: assert property (dme_set && !nmi_in |=> dme_q) // R3
    else $error("enable write did not set master enable");
  a_master_holds: assert property (!nmi_in && !dme_set |=> dme_q == $past(dme_q)) // R4
    else $error("master enable changed without cause");
  a_dest_increment: assert property ( // R5
    ch0_go && dkind == dma_ctrl_pkg::KIND_MEM_INC && !wr_in
    |=> dst0_q == $past(dst0_q) + 20'h0_0001)
    else $error("destination did not increment");
  a_src_fixed: assert property ( // R6
    ch0_go && skind[1] && !wr_in |=> src0_q == $past(src0_q))
    else $error("fixed source pointer moved");
  a_reserved_idle: assert property (ch0_reserved |-> !ch0_go) // R7
    else $error("reserved mode transferred");
  a_mem_self_paced: assert property ( // R9
    ch0_ready && !ch0_io && pace_q == dma_ctrl_pkg::PACE_IDLE
    |=> xfer_valid_out && !xfer_channel_out && !src_is_io_out && !dst_is_io_out)
    else $error("memory move waited for request");
  a_burst_holds_bus: assert property ( // R11
    ch0_go && burst && !ch0_io && !ch0_last && !wr_in && !nmi_in |=> ch0_go ##1 bus_hold_out)
    else $error("burst released bus early");
  a_steal_gap: assert property ( // R12
    ch0_go && !burst && !ch0_io && !ch0_last && !wr_in && !nmi_in ##1 !wr_in && !nmi_in
    |-> s_give_back)
    else $error("cycle steal gap missing");
  a_io_paced: assert property ( // R13
    xfer_valid_out && !xfer_channel_out && (src_is_io_out || dst_is_io_out) |-> $past(req0))
    else $error("io transfer without request");
  a_terminal_clear: assert property ( // R17
    ch0_go && ch0_last && !set0 |=> !de0_q ##0 (irq_out || !ch0_irq_enable_q))
    else $error("termination did not clear enable");
  a_hold_when_off: assert property ( // R19
    !dme_q && !wr_in |=> src0_q == $past(src0_q) && cnt0_q == $past(cnt0_q))
    else $error("channel state moved while suspended");
endmodule : dma_ctrl

// >>> verification/periph_model.sv
`timescale 1ns/10ps
module periph_model #(
  parameter logic CHAN = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic raise_in,
  input wire logic edge_mode_in,
  input wire logic xfer_valid_in,
  input wire logic xfer_channel_in,
  output logic req_out
);
  // Edge mode: short strobe; level mode: held until served
  logic [1:0] hold_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_out <= 1'b0;
      hold_q <= 2'h0;
    end else if (raise_in) begin
      req_out <= 1'b1;
      hold_q <= 2'h3;
    end else if (edge_mode_in && hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
      req_out <= (hold_q != 2'h1);
    end else if (!edge_mode_in && xfer_valid_in && xfer_channel_in == CHAN) begin
      req_out <= 1'b0;
      // Served: no leftover countdown if edge sensing is chosen later
      hold_q <= 2'h0;
    end
  end
endmodule : periph_model

// >>> verification/dma_ch0_mode_and_master_enable_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module dma_ch0_mode_and_master_enable_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic nmi_in = 1'b0;
  logic raise0 = 1'b0;
  logic raise1 = 1'b0;
  logic req0, req1, irq_out, bus_hold_out, xv, xc, sio, dio;
  logic [7:0] rdata_out;
  logic [7:0] wait_control_out;
  logic [19:0] sa, da;
  logic [43:0] q[$];
  int cy[$];
  int cyc = 0;
  int mismatches = 0;
  int cmp_count = 0;
  int n;

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (xv === 1'b1) begin
      q.push_back({bus_hold_out, xc, sio, dio, sa, da});
      cy.push_back(cyc);
    end
  end

  dma_ctrl i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .nmi_in(nmi_in), .ch0_request_in(req0), .ch1_request_in(req1), .irq_out(irq_out),
    .bus_hold_out(bus_hold_out), .xfer_valid_out(xv), .xfer_channel_out(xc),
    .src_addr_out(sa), .dst_addr_out(da), .src_is_io_out(sio), .dst_is_io_out(dio),
    .wait_control_out(wait_control_out));
  periph_model #(.CHAN(1'b0)) i_p0 (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .raise_in(raise0), .edge_mode_in(wait_control_out[2]), .xfer_valid_in(xv),
    .xfer_channel_in(xc), .req_out(req0));
  periph_model #(.CHAN(1'b1)) i_p1 (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .raise_in(raise1), .edge_mode_in(wait_control_out[3]), .xfer_valid_in(xv),
    .xfer_channel_in(xc), .req_out(req1));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask : rdc
  // Multi-byte registers go low byte first
  task automatic w3(input logic [7:0] a, input logic [23:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
    wr(a + 8'h02, v[23:16]);
  endtask : w3
  task automatic w2(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask : w2
  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
  endtask : idle
  // Bit 0 interrupt, bit 1 channel 0 request, bit 2 channel 1 request
  task automatic pulse(input logic [2:0] w);
    @(posedge clk_in);
    {raise1, raise0, nmi_in} <= w;
    @(posedge clk_in);
    {raise1, raise0, nmi_in} <= 3'h0;
  endtask : pulse
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wait_ev(input int k);
    int i;
    for (i = 0; i < 300 && q.size() < k; i++) begin
      @(posedge clk_in);
    end
    if (q.size() < k) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_ev
  // Starts a channel 0 job; write mask 0 so the enable takes
  task automatic job0(input logic [7:0] m, input logic [23:0] s, input logic [23:0] d,
                      input logic [15:0] c, input logic [7:0] st);
    wr(dma_ctrl_pkg::ADDR_MODE, m);
    w3(dma_ctrl_pkg::ADDR_SRC0, s);
    w3(dma_ctrl_pkg::ADDR_DST0, d);
    w2(dma_ctrl_pkg::ADDR_CNT0, c);
    q.delete();
    cy.delete();
    wr(dma_ctrl_pkg::ADDR_STATUS, st);
  endtask : job0

  initial begin
    idle(16);
    rst_n_in <= 1'b1;
    rdc(8'h30, 8'h30);
    rdc(8'h31, 8'h00);
    rdc(8'h32, 8'hf0);
    rdc(8'h40, 8'h00);
    wr(8'h31, 8'hff);
    rdc(8'h31, dma_ctrl_pkg::MODE_WRITABLE);
    wr(8'h30, 8'h01);
    rdc(8'h30, 8'h30);
    wr(8'h30, 8'h50);
    rdc(8'h30, 8'h30);
    // Burst, both pointers step up, interrupt on end
    job0(8'h02, 24'h00_0100, 24'h00_0200, 16'h0003, 8'h44);
    wait_ev(3);
    for (int i = 0; i < 3; i++) begin
      `CHK(q[i], {4'h8, 20'h0_0100 + 20'(i), 20'h0_0200 + 20'(i)})
      `CHK(cy[i] - cy[0], i)
    end
    idle(5);
    `CHK(q.size(), 3)
    rdc(8'h30, 8'h35);
    `CHK(irq_out, 1'b1)
    rdc(8'h26, 8'h00);
    // Cycle steal, fixed source, decrementing destination
    job0(8'h18, 24'h00_0400, 24'h00_0500, 16'h0002, 8'h40);
    wait_ev(2);
    `CHK(q[0], {4'h8, 20'h0_0400, 20'h0_0500})
    `CHK(q[1], {4'h8, 20'h0_0400, 20'h0_04ff})
    `CHK(cy[1] - cy[0], 2)
    `CHK(irq_out, 1'b0)
    // Suspend by the interrupt, then resume where it stopped
    // Long enough that the interrupt lands mid-burst
    job0(8'h02, 24'h00_0600, 24'h00_0700, 16'h0010, 8'h40);
    wait_ev(1);
    pulse(3'h1);
    idle(5);
    n = q.size();
    rdc(8'h30, 8'h70);
    idle(5);
    `CHK(q.size(), n)
    rdc(8'h26, 8'(16 - n));
    wr(8'h30, 8'h40);
    wait_ev(16);
    for (int i = 0; i < 16; i++) begin
      `CHK(q[i], {4'h8, 20'h0_0600 + 20'(i), 20'h0_0700 + 20'(i)})
    end
    rdc(8'h30, 8'h31);
    // Fixed memory to fixed memory is reserved: never moves
    job0(8'h28, 24'h00_0900, 24'h00_0a00, 16'h0002, 8'h40);
    idle(20);
    `CHK(q.size(), 0)
    rdc(8'h30, 8'h71);
    wr(8'h30, 8'h00);
    // I/O destination waits for the request, timing bit ignored
    job0(8'h32, 24'h00_0800, 24'h00_0050, 16'h0002, 8'h40);
    idle(10);
    `CHK(q.size(), 0)
    pulse(3'h2);
    wait_ev(2);
    `CHK(q[0], {4'h9, 20'h0_0800, 20'h0_0050})
    `CHK(q[1], {4'h9, 20'h0_0801, 20'h0_0050})
    // Channel 1 edge sensed, I/O to memory
    wr(dma_ctrl_pkg::ADDR_WAITCTL, 8'hfa);
    w3(dma_ctrl_pkg::ADDR_MEM1, 24'h00_0300);
    w2(dma_ctrl_pkg::ADDR_IO1, 16'h0040);
    w2(dma_ctrl_pkg::ADDR_CNT1, 16'h0001);
    q.delete();
    wr(8'h30, 8'h90);
    idle(10);
    `CHK(q.size(), 0)
    pulse(3'h4);
    wait_ev(1);
    `CHK(q[0], {4'he, 20'h0_0040, 20'h0_0300})
    `CHK(wait_control_out, 8'hfa)
    rdc(8'h30, 8'h31);
    // Channel 0 edge sensed, I/O source: one byte per edge
    wr(dma_ctrl_pkg::ADDR_WAITCTL, 8'hf5);
    job0(8'h0c, 24'h00_0060, 24'h00_0a00, 16'h0002, 8'h40);
    pulse(3'h2);
    wait_ev(1);
    idle(10);
    `CHK(q.size(), 1)
    pulse(3'h2);
    wait_ev(2);
    `CHK(q[0], {4'ha, 20'h0_0060, 20'h0_0a00})
    `CHK(q[1], {4'ha, 20'h0_0060, 20'h0_0a01})
    wrap_up();
  end
endmodule : dma_ch0_mode_and_master_enable_tb
